// ---- design/fpt_pkg.sv ----
package fpt_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_FAN_A_SEL = 8'h56;
    localparam logic [7:0] IDX_FAN_B     = 8'h57;
    localparam logic [7:0] IDX_CTRL      = 8'h58;
    localparam logic [7:0] IDX_TACH_A    = 8'h59;

    // Reset values, applied on the standby power-on reset
    localparam logic [7:0] RST_FAN_A_SEL = 8'h00;
    localparam logic [7:0] RST_FAN_B     = 8'h00;
    localparam logic [7:0] RST_CTRL      = 8'h50;
    localparam logic [7:0] RST_TACH      = 8'h00;

    // Fan output register fields
    localparam int FANB_FORCE_BIT = 0;
    localparam int DUTY_LSB       = 1;
    localparam int DUTY_W         = 6;
    localparam int CLK_SEL_BIT    = 7;

    // Fan clocking control fields; fan B fields sit one slot above fan A
    localparam int CTRL_SRC_A_BIT  = 0;
    localparam int CTRL_MULT_A_BIT = 2;
    localparam int CTRL_DIV_A_LSB  = 4;
    localparam int CTRL_DIV_W      = 2;

    // Timing
    localparam int PWM_STEP_NS  = 400;
    localparam int PWM_STEP_CYC = (PWM_STEP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int MON_BASE0_NS = 40000;
    localparam int MON_BASE1_NS = 20000;
    localparam int MON_BASE2_NS = 10000;
    localparam int MON_BASE3_NS = 5000;
    localparam int MON_BASE0_CYC = MON_BASE0_NS / CLK_PERIOD_NS;
    localparam int MON_BASE1_CYC = MON_BASE1_NS / CLK_PERIOD_NS;
    localparam int MON_BASE2_CYC = MON_BASE2_NS / CLK_PERIOD_NS;
    localparam int MON_BASE3_CYC = MON_BASE3_NS / CLK_PERIOD_NS;

    // Widths and limits
    localparam int PER_W = 16;
    localparam int PWM_DIV_W = 8;
    localparam logic [7:0] TACH_SAT = 8'hff;

endpackage : fpt_pkg

// ---- design/fpt_mon_tick.sv ----
`timescale 1ns/10ps
module fpt_mon_tick (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Speed selection
    input  wire logic       src_sel_i,
    input  wire logic       clk_sel_i,
    input  wire logic       mult_i,
    input  wire logic [1:0] div_i,
    // Monitoring clock enable
    output logic            tick_o
);

    typedef struct packed {
        logic [fpt_pkg::PER_W-1:0] cnt;
        logic                      tick;
    } fpt_tick_st_t;

    fpt_tick_st_t st_ff;
    fpt_tick_st_t nxt_st;
    logic [fpt_pkg::PER_W-1:0] period;

    function automatic logic [fpt_pkg::PER_W-1:0] base_period(
        input logic [1:0] code);
        logic [fpt_pkg::PER_W-1:0] p;
        p = fpt_pkg::PER_W'(fpt_pkg::MON_BASE0_CYC);
        case (code)
            2'h1: p = fpt_pkg::PER_W'(fpt_pkg::MON_BASE1_CYC);
            2'h2: p = fpt_pkg::PER_W'(fpt_pkg::MON_BASE2_CYC);
            2'h3: p = fpt_pkg::PER_W'(fpt_pkg::MON_BASE3_CYC);
            default: p = fpt_pkg::PER_W'(fpt_pkg::MON_BASE0_CYC);
        endcase
        return p;
    endfunction : base_period

    always_comb begin
        // Source and clock select pick the base rate [R4] [R6] [R7]
        period = base_period({src_sel_i, clk_sel_i}) << div_i; // [R10]
        if (mult_i) begin
            period = period >> 1; // [R5] [R8] [R9]
        end
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        // >= so a shorter period chosen mid-count takes effect at once
        if (st_ff.cnt >= period - 16'h0001) begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;

    a_tick_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tick_o |=> !tick_o [*8]) // [R10]
        else $error("monitor tick repeated too soon");

endmodule : fpt_mon_tick

// ---- design/fpt_fan_ctrl.sv ----
// Overview of operation
// (R1) Bit0 clear: duty field drives fan B
// (R2) Bit0 set: fan B output held high
// (R3) Duty 0 low, 32 half, 63 of 64
// (R4) Fan B select bit joins control bits
// (R5) Fan B speed doubles via control bit3
// (R6) Control bit0 picks fan A speed clock
// (R7) Control bit1 picks fan B speed clock
// (R8) Control bit2 doubles fan A speed
// (R9) Control bit3 doubles fan B speed
// (R10) Divisor fields scale 1,2,4,8, default 2
// (R11) Count clocks per fan A tach pulse
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module fpt_fan_ctrl (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Fan side
    input  wire logic        fan_a_tach_i,
    output logic             fan_b_output_o,
    output logic             fan_b_mon_tick_o
);

    typedef struct packed {
        logic [7:0]                      fan_a_sel;
        logic [7:0]                      fan_b;
        logic [7:0]                      ctrl;
        logic [7:0]                      tach_cnt;
        logic [7:0]                      tach_run;
        logic                            tach_prev;
        logic [fpt_pkg::PWM_DIV_W-1:0]   pwm_div;
        logic [fpt_pkg::DUTY_W-1:0]      pwm_phase;
        logic                            pwm_out;
        logic                            ack;
        logic [7:0]                      rdata;
    } fpt_ctrl_st_t;

    localparam fpt_ctrl_st_t ST_RESET = '{
        fan_a_sel: fpt_pkg::RST_FAN_A_SEL,
        fan_b:     fpt_pkg::RST_FAN_B,
        ctrl:      fpt_pkg::RST_CTRL,
        tach_cnt:  fpt_pkg::RST_TACH,
        tach_run:  8'h00,
        tach_prev: 1'b0,
        pwm_div:   '0,
        pwm_phase: '0,
        pwm_out:   1'b0,
        ack:       1'b0,
        rdata:     8'h00
    };

    fpt_ctrl_st_t st_ff;
    fpt_ctrl_st_t nxt_st;

    logic [7:0]                 idx;
    logic [fpt_pkg::DUTY_W-1:0] duty;
    logic                       force_hi;
    logic                       tach_rise;
    logic [1:0]                 mon_tick;
    logic [1:0]                 clk_sel_bits;

    // Register read mux; unmapped indexes read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] i,
                                             input fpt_ctrl_st_t s);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            fpt_pkg::IDX_FAN_A_SEL: v = s.fan_a_sel;
            fpt_pkg::IDX_FAN_B:     v = s.fan_b;
            fpt_pkg::IDX_CTRL:      v = s.ctrl;
            fpt_pkg::IDX_TACH_A:    v = s.tach_cnt;
            default:                v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    assign idx = wb_adr_i[9:2];
    assign duty = st_ff.fan_b[fpt_pkg::DUTY_LSB +: fpt_pkg::DUTY_W];
    assign force_hi = st_ff.fan_b[fpt_pkg::FANB_FORCE_BIT];
    assign tach_rise = fan_a_tach_i & ~st_ff.tach_prev;
    assign clk_sel_bits = {st_ff.fan_b[fpt_pkg::CLK_SEL_BIT],
                           st_ff.fan_a_sel[fpt_pkg::CLK_SEL_BIT]};

    // One monitoring clock per fan
    for (genvar g = 0; g < 2; g++) begin : g_mon
        fpt_mon_tick u_mon (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .src_sel_i (st_ff.ctrl[fpt_pkg::CTRL_SRC_A_BIT + g]),
            .clk_sel_i (clk_sel_bits[g]),
            .mult_i    (st_ff.ctrl[fpt_pkg::CTRL_MULT_A_BIT + g]),
            .div_i     (st_ff.ctrl[fpt_pkg::CTRL_DIV_A_LSB
                                   + g * fpt_pkg::CTRL_DIV_W +: 2]),
            .tick_o    (mon_tick[g])
        ); // [R4] [R5] [R6] [R7] [R8] [R9] [R10]
    end

    always_comb begin
        nxt_st = st_ff;

        // Bus: ack one cycle after the request; writes land on the ack
        // edge so the master sees them exactly when it samples ack
        nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
        nxt_st.rdata = 8'h00;
        if (wb_cyc_i & wb_stb_i & ~st_ff.ack & ~wb_we_i) begin
            nxt_st.rdata = reg_read(idx, st_ff);
        end
        if (st_ff.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]) begin
            case (idx)
                fpt_pkg::IDX_FAN_A_SEL: begin
                    nxt_st.fan_a_sel = {wb_dat_i[fpt_pkg::CLK_SEL_BIT],
                                        7'h00};
                end
                fpt_pkg::IDX_FAN_B: begin
                    nxt_st.fan_b = wb_dat_i[7:0];
                end
                fpt_pkg::IDX_CTRL: begin
                    nxt_st.ctrl = wb_dat_i[7:0]; // [R10]
                end
                default: begin
                    nxt_st.fan_b = st_ff.fan_b;
                end
            endcase
        end

        // PWM: 64 steps per period, step rate from a divider
        if (st_ff.pwm_div == fpt_pkg::PWM_DIV_W'(fpt_pkg::PWM_STEP_CYC - 1))
        begin
            nxt_st.pwm_div = '0;
            nxt_st.pwm_phase = st_ff.pwm_phase + 6'h01;
        end else begin
            nxt_st.pwm_div = st_ff.pwm_div + 8'h01;
        end
        if (force_hi) begin
            nxt_st.pwm_out = 1'b1; // [R2]
        end else begin
            nxt_st.pwm_out = (st_ff.pwm_phase < duty); // [R1] [R3]
        end

        // Tach: count monitor ticks between rising tach edges
        nxt_st.tach_prev = fan_a_tach_i;
        if (tach_rise) begin
            nxt_st.tach_cnt = st_ff.tach_run; // [R11]
            nxt_st.tach_run = 8'h00;
        end else if (mon_tick[0] && st_ff.tach_run != fpt_pkg::TACH_SAT)
        begin
            // Saturates so a pulse after a long stall latches full scale, not a wrap
            nxt_st.tach_run = st_ff.tach_run + 8'h01; // [R11]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.rdata};
    assign fan_b_output_o = st_ff.pwm_out;
    assign fan_b_mon_tick_o = mon_tick[1];

    // Checks
    sequence s_req_new;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_ack_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_req_new |=> s_ack_pulse)
        else $error("ack not a single cycle after request");

    a_force_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        force_hi |=> fan_b_output_o) // [R2]
        else $error("fan B not high while forced");

    a_duty_compare: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !force_hi |=> fan_b_output_o ==
                      ($past(st_ff.pwm_phase) < $past(duty))) // [R1]
        else $error("fan B output does not follow duty");

    a_duty_zero_low: assert property (@(posedge sys_clk_i)
        disable iff (rst_i)
        (!force_hi && duty == 6'h00) [*2] |-> !fan_b_output_o) // [R3]
        else $error("zero duty did not hold pin low");

    a_duty_half: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!force_hi && duty == 6'h20) |=>
        fan_b_output_o == !$past(st_ff.pwm_phase[5])) // [R3]
        else $error("half duty wrong");

    a_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
         && idx == fpt_pkg::IDX_CTRL)
        |=> st_ff.ctrl == $past(wb_dat_i[7:0])) // [R10]
        else $error("control write not stored");

    a_tach_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tach_rise |=> st_ff.tach_cnt == $past(st_ff.tach_run)
                      && st_ff.tach_run == 8'h00) // [R11]
        else $error("tach count not latched on pulse");

    a_tach_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!tach_rise && mon_tick[0] && st_ff.tach_run != 8'hff)
        |=> st_ff.tach_run == $past(st_ff.tach_run) + 8'h01) // [R11]
        else $error("tach run count missed a tick");

    a_tach_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!tach_rise && st_ff.tach_run == 8'hff) |=>
        st_ff.tach_run == 8'hff) // [R11]
        else $error("tach run count wrapped");

    // Write and read hits at one register index, for the checks below
    sequence s_wr_hit(logic [7:0] which);
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && idx == which;
    endsequence

    sequence s_rd_new(logic [7:0] which);
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && idx == which;
    endsequence

    a_ack_has_req: assert property (@(posedge sys_clk_i)
        disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");

    a_idle_dat_zero: assert property (@(posedge sys_clk_i)
        disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside an answer");

    a_fan_b_write: assert property (@(posedge sys_clk_i) // [R1]
        disable iff (rst_i)
        s_wr_hit(fpt_pkg::IDX_FAN_B)
        |=> st_ff.fan_b == $past(wb_dat_i[7:0]))
        else $error("fan B register write not stored");

    a_sel_write: assert property (@(posedge sys_clk_i) // [R6]
        disable iff (rst_i)
        s_wr_hit(fpt_pkg::IDX_FAN_A_SEL)
        |=> st_ff.fan_a_sel == {$past(wb_dat_i[fpt_pkg::CLK_SEL_BIT]), 7'h00})
        else $error("fan A select write not stored");

    a_lane_off: assert property (@(posedge sys_clk_i) // [R10]
        disable iff (rst_i)
        (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0])
        |=> $stable(st_ff.ctrl) && $stable(st_ff.fan_b)
            && $stable(st_ff.fan_a_sel))
        else $error("write with lane 0 off changed a register");

    a_read_ctrl: assert property (@(posedge sys_clk_i) // [R10]
        disable iff (rst_i)
        s_rd_new(fpt_pkg::IDX_CTRL) |=> wb_dat_o[7:0] == $past(st_ff.ctrl))
        else $error("control read wrong");

    a_read_fan_b: assert property (@(posedge sys_clk_i) // [R1]
        disable iff (rst_i)
        s_rd_new(fpt_pkg::IDX_FAN_B) |=> wb_dat_o[7:0] == $past(st_ff.fan_b))
        else $error("fan B register read wrong");

    a_read_tach: assert property (@(posedge sys_clk_i) // [R11]
        disable iff (rst_i)
        s_rd_new(fpt_pkg::IDX_TACH_A)
        |=> wb_dat_o[7:0] == $past(st_ff.tach_cnt))
        else $error("tach count read wrong");

    a_tach_hold: assert property (@(posedge sys_clk_i) // [R11]
        disable iff (rst_i)
        !tach_rise |=> $stable(st_ff.tach_cnt))
        else $error("tach count changed without a pulse");

    a_run_hold: assert property (@(posedge sys_clk_i) // [R11]
        disable iff (rst_i)
        (!tach_rise && !mon_tick[0]) |=> $stable(st_ff.tach_run))
        else $error("tach run count moved without a tick");

    a_duty_full: assert property (@(posedge sys_clk_i) // [R3]
        disable iff (rst_i)
        (!force_hi && duty == 6'h3f)
        |=> fan_b_output_o == ($past(st_ff.pwm_phase) != 6'h3f))
        else $error("full duty not low for one step");

    // The phase moves only when the step divider wraps
    a_pwm_hold: assert property (@(posedge sys_clk_i) // [R3]
        disable iff (rst_i)
        (st_ff.pwm_div != fpt_pkg::PWM_DIV_W'(fpt_pkg::PWM_STEP_CYC - 1))
        |=> $stable(st_ff.pwm_phase))
        else $error("PWM phase moved inside a step");

    a_pwm_div_range: assert property (@(posedge sys_clk_i) // [R3]
        disable iff (rst_i)
        st_ff.pwm_div <= fpt_pkg::PWM_DIV_W'(fpt_pkg::PWM_STEP_CYC - 1))
        else $error("PWM step divider out of range");

endmodule : fpt_fan_ctrl

// ---- test/fpt_fan_model.sv ----
`timescale 1ns/10ps
module fpt_fan_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Pulse spacing in clock cycles; zero parks the fan
    input  wire logic [15:0] period_i,
    // Tachometer pulse towards the block
    output logic             tach_o
);
    logic [15:0] cnt_ff;

    // Short pulse at the start of each turn; a parked fan reads low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || period_i == 16'h0000) begin
            cnt_ff <= 16'h0000;
            tach_o <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff >= period_i - 16'h0001) ? 16'h0000
                                                      : cnt_ff + 16'h0001;
            tach_o <= (cnt_ff < 16'h0004);
        end
    end
endmodule : fpt_fan_model

// ---- test/fpt_fan_ctrl_tb.sv ----
`timescale 1ns/10ps
module fpt_fan_ctrl_tb;
    typedef struct packed {
        logic [7:0] idx;
        logic [3:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
    } fpt_row_t;

    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [9:0]  wb_adr_i  = 10'h000;
    logic [3:0]  wb_sel_i  = 4'h0;
    logic [31:0] wb_dat_i  = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        fan_a_tach_i;
    logic        fan_b_output_o;
    logic        fan_b_mon_tick_o;
    logic [15:0] tach_period = 16'h0000;
    logic [7:0]  rd;
    int          c;
    int          fail_count = 0;
    int          cmp_count = 0;

    // Sel 4'he leaves lane 0 off, so that write must not land
    fpt_row_t rows [6] = '{'{8'h57, 4'h1, 8'ha5, 8'ha5},
        '{8'h56, 4'h1, 8'hff, 8'h80}, '{8'h58, 4'hf, 8'h3c, 8'h3c},
        '{8'h58, 4'he, 8'hff, 8'h3c}, '{8'h59, 4'h1, 8'hff, 8'h00},
        '{8'h3f, 4'h1, 8'hff, 8'h00}};
    logic [7:0]  rst_exp [4] = '{8'h00, 8'h00, 8'h50, 8'h00};
    logic [7:0]  duty_v [4]  = '{8'h00, 8'h40, 8'h7e, 8'h01};
    int          duty_hi [4] = '{0, 1280, 2520, 2560};
    // Control value, fan B register value, expected tick spacing
    logic [7:0]  tk_c [6] = '{8'h00, 8'h00, 8'h02, 8'h82, 8'hca, 8'h0a};
    logic [7:0]  tk_b [6] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'h00};
    int          tk_e [6] = '{4000, 2000, 1000, 2000, 2000, 500};

    always #5 sys_clk_i = ~sys_clk_i;

    fpt_fan_ctrl dut_u (
        .sys_clk_i        (sys_clk_i),
        .rst_i            (rst_i),
        .wb_cyc_i         (wb_cyc_i),
        .wb_stb_i         (wb_stb_i),
        .wb_we_i          (wb_we_i),
        .wb_adr_i         (wb_adr_i),
        .wb_sel_i         (wb_sel_i),
        .wb_dat_i         (wb_dat_i),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .fan_a_tach_i     (fan_a_tach_i),
        .fan_b_output_o   (fan_b_output_o),
        .fan_b_mon_tick_o (fan_b_mon_tick_o)
    );

    fpt_fan_model fan_u (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .period_i  (tach_period),
        .tach_o    (fan_a_tach_i)
    );

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Single classic cycle; waits for ack with no assumed latency
    task automatic wb_xfer(input logic we, input logic [7:0] idx,
                           input logic [3:0] sel, input logic [7:0] wd,
                           output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, wd};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 50) fail_count++;
    endtask : wb_xfer

    // Spacing between two monitoring ticks, after the first one seen
    task automatic measure(output int cnt);
        int n;
        n = 0;
        cnt = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (fan_b_mon_tick_o !== 1'b1 && n < 40000);
        do begin
            @(posedge sys_clk_i);
            cnt++;
        end while (fan_b_mon_tick_o !== 1'b1 && cnt < 40000);
    endtask : measure

    initial begin
        repeat (90000) @(posedge sys_clk_i);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb_xfer(1'b0, fpt_pkg::IDX_FAN_A_SEL + 8'(i), 4'h1, 8'h00, rd);
            check(rd, rst_exp[i]);
        end
        measure(c);
        check(c, 8000);
        $display("test reset values done");
        foreach (rows[i]) begin
            wb_xfer(1'b1, rows[i].idx, rows[i].sel, rows[i].wd, rd);
            wb_xfer(1'b0, rows[i].idx, 4'h1, 8'h00, rd);
            check(rd, rows[i].exp);
        end
        $display("test register rows done");
        foreach (duty_v[i]) begin
            wb_xfer(1'b1, fpt_pkg::IDX_FAN_B, 4'h1, duty_v[i], rd);
            repeat (2560) @(posedge sys_clk_i);
            c = 0;
            repeat (2560) begin
                @(posedge sys_clk_i);
                if (fan_b_output_o === 1'b1) c++;
            end
            check(c, duty_hi[i]);
        end
        $display("test duty done");
        foreach (tk_c[i]) begin
            wb_xfer(1'b1, fpt_pkg::IDX_FAN_B, 4'h1, tk_b[i], rd);
            wb_xfer(1'b1, fpt_pkg::IDX_CTRL, 4'h1, tk_c[i], rd);
            measure(c);
            check(c, tk_e[i]);
        end
        $display("test speed select done");
        // Fan A at 250 then 500 cycles a count, pulses 2500 apart
        wb_xfer(1'b1, fpt_pkg::IDX_FAN_A_SEL, 4'h1, 8'h80, rd);
        tach_period <= 16'd2500;
        for (int i = 0; i < 2; i++) begin
            wb_xfer(1'b1, fpt_pkg::IDX_CTRL, 4'h1, 8'(i ? 1 : 5), rd);
            repeat (7500) @(posedge sys_clk_i);
            wb_xfer(1'b0, fpt_pkg::IDX_TACH_A, 4'h1, 8'h00, rd);
            c = i ? 5 : 10;
            check(32'(rd >= 8'(c - 1) && rd <= 8'(c + 1)), 1);
        end
        $display("test tach count done");
        tach_period <= 16'h0000;
        rst_i <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, fpt_pkg::IDX_CTRL, 4'h1, 8'h00, rd);
        check(rd, fpt_pkg::RST_CTRL);
        $display("test second reset done");
        test_done();
    end
endmodule : fpt_fan_ctrl_tb
